// [core/bcd_port_pkg.sv]
package bcd_port_pkg;

  // ==========================================================
  // Data layout
  localparam int DIGIT_W = 4;
  localparam int DIGITS  = 6;
  localparam int DATA_W  = DIGIT_W * DIGITS;
  localparam int HALF_W  = DATA_W / 2;
  localparam int DP_W    = 3;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  CFG_OFFSET    = 8'h00;
  localparam logic [7:0]  VALUE_OFFSET  = 8'h04;
  localparam logic [7:0]  AUX_OFFSET    = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET = 8'h0C;

  // ==========================================================
  // Strap register fields
  localparam int CFG_W              = 12;
  localparam int CFG_OVF_ROUTE      = 0;
  localparam int CFG_MUX_SELECT     = 1;
  localparam int CFG_SINGLE_ADDR    = 2;
  localparam int CFG_QUAD_ADDR      = 3;
  localparam int CFG_MUX_COMPANION  = 4;
  localparam int CFG_SIX_DIGIT      = 5;
  localparam int CFG_B2_LEVEL       = 6;
  localparam int CFG_B1_LEVEL       = 7;
  localparam int CFG_B8_LEVEL       = 8;
  localparam int CFG_B4_LEVEL       = 9;
  localparam int CFG_NEG_POLARITY   = 10;
  localparam int CFG_POS_POLARITY   = 11;
  localparam logic [11:0] CFG_RESET = 12'h828;

  // ==========================================================
  // Auxiliary value fields
  localparam int          AUX_W        = 5;
  localparam int          AUX_DP_LSB   = 0;
  localparam int          AUX_SIGN     = 3;
  localparam int          AUX_OVF      = 4;
  localparam logic [4:0]  AUX_RESET    = 5'h01;
  localparam logic [2:0]  DP_RIGHTMOST = 3'h1;
  localparam logic [2:0]  DP_LEFTMOST  = 3'h6;
  localparam logic [23:0] VALUE_RESET  = 24'h000000;

  // ==========================================================
  // Status fields
  localparam int ST_PENDING = 0;
  localparam int ST_HOLD    = 1;
  localparam int ST_MARKER  = 2;
  localparam int ST_ENABLE  = 3;
  localparam int ST_UPPER   = 4;
  localparam int ST_MUX     = 5;
  localparam int ST_CNT_LSB = 8;
  localparam int UPD_CNT_W  = 8;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_MHZ = 250;
  localparam int MARKER_NS    = 200000;
  localparam int MARKER_CYC   = MARKER_NS * CLK_FREQ_MHZ / 1000;
  localparam int MARKER_CNT_W = 16;

endpackage

// [core/address_match.sv]
`timescale 1ns/100ps
// ==========================================================
// Address line compare: each line against its level strap
module address_match #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] line_i,
  input  wire logic [W-1:0] level_strap_i,
  output logic              match_o
);

  // Fitted strap wants low, removed strap wants high or open
  assign match_o = &(line_i ^ level_strap_i);

endmodule // address_match

// [core/marker_timer.sv]
`timescale 1ns/100ps
// ==========================================================
// One-shot timer for the update marker
module marker_timer #(
  parameter int                CNT_W  = 16,
  parameter logic [CNT_W-1:0]  CYCLES = 16'hC350
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic start_i,
  output logic      active_o
);

  logic [CNT_W-1:0] remain;

  // Load on start, count down to zero; a new start restarts
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      remain <= '0;
    end else if (start_i) begin
      remain <= CYCLES;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign active_o = (remain != '0);

endmodule // marker_timer

// [core/bcd_parallel_output_port.sv]
`timescale 1ns/100ps
// Contract
// (R01) Present reading as parallel BCD digits
// (R02) Drive stored copy; tri-state when unaddressed
// (R03) Three-digit multiplexed or six-digit readout
// (R04) Overflow line driven only with route strap
// (R05) Multiplex strap selects three-digit mode
// (R06) Single-address strap: enable by b1 alone
// (R07) Quad strap: all four lines must match
// (R08) Six-digit strap selects full readout
// (R09) b2 level strap: low needed, else high
// (R10) b1 level strap: low needed, else high
// (R11) b8 level strap: low needed, else high
// (R12) b4 level strap: low needed, else high
// (R13) Negative strap inverts data and point code
// (R14) Positive strap drives data uninverted
// (R15) Hold low freezes; release updates all digits
// (R16) Update marker low about 200 us
// (R17) Quad mode XORs lines, ANDs into enable
// (R18) Point code 001 rightmost to 110 leftmost
// (R19) Straps are static, sampled continuously
// (R20) Mux mode puts upper digits on lower lines
module bcd_parallel_output_port #(
  parameter int                                   MARKER_CNT_W =
    bcd_port_pkg::MARKER_CNT_W,
  parameter logic [MARKER_CNT_W-1:0]               MARKER_CYCLES =
    MARKER_CNT_W'(bcd_port_pkg::MARKER_CYC)
) (
  input  wire logic                              mclk_i,
  input  wire logic                              rstn_i,
  // APB slave
  input  wire logic                              psel_i,
  input  wire logic                              penable_i,
  input  wire logic                              pwrite_i,
  input  wire logic [bcd_port_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [31:0]                       pwdata_i,
  input  wire logic [3:0]                        pstrb_i,
  output logic [31:0]                            prdata_o,
  output logic                                   pready_o,
  output logic                                   pslverr_o,
  // Connector side
  input  wire logic                              hold_n_i,
  input  wire logic                              addr_b1_line_i,
  input  wire logic                              addr_b2_line_i,
  input  wire logic                              addr_b4_line_i,
  input  wire logic                              addr_b8_line_i,
  output logic [bcd_port_pkg::HALF_W-1:0]        bcd_low_o,
  output logic                                   bcd_low_oe_o,
  output logic [bcd_port_pkg::HALF_W-1:0]        bcd_high_o,
  output logic                                   bcd_high_oe_o,
  output logic [bcd_port_pkg::DP_W-1:0]          dp_code_o,
  output logic                                   dp_code_oe_o,
  output logic                                   polarity_o,
  output logic                                   polarity_oe_o,
  output logic                                   overflow_out_line_o,
  output logic                                   overflow_out_line_oe_o,
  output logic                                   data_ready_n_o
);
  import bcd_port_pkg::*;

  // ==========================================================
  // Software state
  logic [CFG_W-1:0]     cfg;
  logic [DATA_W-1:0]    staged_value;
  logic [AUX_W-1:0]     staged_aux;
  logic                 pending;
  logic [UPD_CNT_W-1:0] update_count;

  // Stored, buffered copy that drives the pins
  logic [DATA_W-1:0]    stored_value;
  logic [AUX_W-1:0]     stored_aux;

  logic                 setup_phase;
  logic                 access_wr;
  logic                 addr_known;
  logic                 addr_writable;
  logic [31:0]          wr_mask;
  logic [31:0]          status_word;
  logic [31:0]          next_rdata;
  logic [31:0]          merged_cfg;
  logic [31:0]          merged_value;
  logic [31:0]          merged_aux;
  logic                 wr_value;
  logic                 update;
  logic                 marker_active;

  // Strap decode
  logic                 mux_mode;
  logic                 invert;
  logic                 match_quad;
  logic                 match_b1;
  logic                 match_b2;
  logic                 upper_sel;
  logic                 lower_sel;
  logic                 board_en;
  logic                 next_low_oe;
  logic                 next_high_oe;
  logic [HALF_W-1:0]    next_low;

  // ==========================================================
  // APB decode
  assign setup_phase   = psel_i && !penable_i;
  assign access_wr     = psel_i && penable_i && pwrite_i;
  assign addr_known    = (paddr_i == CFG_OFFSET) ||
                         (paddr_i == VALUE_OFFSET) ||
                         (paddr_i == AUX_OFFSET) ||
                         (paddr_i == STATUS_OFFSET);
  assign addr_writable = (paddr_i == CFG_OFFSET) ||
                         (paddr_i == VALUE_OFFSET) ||
                         (paddr_i == AUX_OFFSET);

  // Zero-wait slave
  assign pready_o = 1'b1;

  // Byte-lane mask from strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{pstrb_i[i]}};
    end
  end

  // Merge write data into current contents
  assign merged_cfg   = (pwdata_i & wr_mask) |
                        ({20'h00000, cfg} & ~wr_mask);
  assign merged_value = (pwdata_i & wr_mask) |
                        ({8'h00, staged_value} & ~wr_mask);
  assign merged_aux   = (pwdata_i & wr_mask) |
                        ({27'h0000000, staged_aux} & ~wr_mask);

  assign wr_value = access_wr && (paddr_i == VALUE_OFFSET);

  // Status view of the block's own state
  always_comb begin
    status_word                               = 32'h00000000;
    status_word[ST_PENDING]                   = pending;
    status_word[ST_HOLD]                      = !hold_n_i;
    status_word[ST_MARKER]                    = marker_active;
    status_word[ST_ENABLE]                    = board_en;
    status_word[ST_UPPER]                     = upper_sel;
    status_word[ST_MUX]                       = mux_mode;
    status_word[ST_CNT_LSB +: UPD_CNT_W]      = update_count;
  end

  // Read data mux
  always_comb begin
    unique case (paddr_i)
      CFG_OFFSET:    next_rdata = {20'h00000, cfg};
      VALUE_OFFSET:  next_rdata = {8'h00, staged_value};
      AUX_OFFSET:    next_rdata = {27'h0000000, staged_aux};
      STATUS_OFFSET: next_rdata = status_word;
      default:       next_rdata = 32'h00000000;
    endcase
  end

  // Read data and error captured in the setup phase
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      prdata_o  <= pwrite_i ? 32'h00000000 : next_rdata;
      pslverr_o <= pwrite_i ? !addr_writable : !addr_known;
    end
  end

  // ==========================================================
  // Strap register, read by the decode every cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg <= CFG_RESET;
    end else if (access_wr && (paddr_i == CFG_OFFSET)) begin
      cfg <= merged_cfg[CFG_W-1:0];                        // R19
    end
  end

  // Staged reading from the meter core
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      staged_value <= VALUE_RESET;
    end else if (wr_value) begin
      staged_value <= merged_value[DATA_W-1:0];            // R01
    end
  end

  // Point code, sign and overflow; bad point codes refused
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      staged_aux <= AUX_RESET;
    end else if (access_wr && (paddr_i == AUX_OFFSET)) begin
      staged_aux[AUX_SIGN] <= merged_aux[AUX_SIGN];
      staged_aux[AUX_OVF]  <= merged_aux[AUX_OVF];
      if (merged_aux[AUX_DP_LSB +: DP_W] >= DP_RIGHTMOST &&
          merged_aux[AUX_DP_LSB +: DP_W] <= DP_LEFTMOST) begin
        staged_aux[AUX_DP_LSB +: DP_W] <=
          merged_aux[AUX_DP_LSB +: DP_W];                  // R18
      end
    end
  end

  // ==========================================================
  // Update: a value write arms it, hold input defers it
  assign update = pending && hold_n_i;                     // R15

  // Pending flag; a new write in the update cycle wins
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pending <= 1'b0;
    end else if (wr_value) begin
      pending <= 1'b1;
    end else if (update) begin
      pending <= 1'b0;
    end
  end

  // All six digits and the extras move in one step
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stored_value <= VALUE_RESET;
      stored_aux   <= AUX_RESET;
    end else if (update) begin
      stored_value <= staged_value;                        // R02 R15
      stored_aux   <= staged_aux;
    end
  end

  // Count of updates for software
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      update_count <= '0;
    end else if (update) begin
      update_count <= update_count + 1'b1;
    end
  end

  // Update marker timing
  marker_timer #(
    .CNT_W  (MARKER_CNT_W),
    .CYCLES (MARKER_CYCLES)
  ) u_marker (
    .mclk_i   (mclk_i),
    .rstn_i   (rstn_i),
    .start_i  (update),
    .active_o (marker_active)
  );

  // Marker is active low and ignores the polarity strap
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_ready_n_o <= 1'b1;
    end else begin
      data_ready_n_o <= !(update || marker_active);        // R16
    end
  end

  // ==========================================================
  // Strap decode for mode and addressing
  assign mux_mode = cfg[CFG_MUX_SELECT] &&
                    cfg[CFG_MUX_COMPANION] &&
                    cfg[CFG_SINGLE_ADDR] &&
                    !cfg[CFG_SIX_DIGIT];                   // R03 R05 R08
  assign invert   = cfg[CFG_NEG_POLARITY] &&
                    !cfg[CFG_POS_POLARITY];                // R13 R14

  // Four lines against their straps, ANDed
  address_match #(
    .W (4)
  ) u_quad (
    .line_i        ({addr_b8_line_i, addr_b4_line_i,
                     addr_b2_line_i, addr_b1_line_i}),
    .level_strap_i ({cfg[CFG_B8_LEVEL], cfg[CFG_B4_LEVEL],
                     cfg[CFG_B2_LEVEL], cfg[CFG_B1_LEVEL]}),
    .match_o       (match_quad)                            // R17
  );

  // b1 alone
  address_match #(
    .W (1)
  ) u_b1 (
    .line_i        (addr_b1_line_i),
    .level_strap_i (cfg[CFG_B1_LEVEL]),                    // R10
    .match_o       (match_b1)
  );

  // b2 alone, for the lower digits in mux mode
  address_match #(
    .W (1)
  ) u_b2 (
    .line_i        (addr_b2_line_i),
    .level_strap_i (cfg[CFG_B2_LEVEL]),                    // R09
    .match_o       (match_b2)
  );

  // Board enable per mode; b4 and b8 straps act in the quad compare
  always_comb begin
    upper_sel = 1'b0;
    lower_sel = 1'b0;
    if (mux_mode) begin
      upper_sel = match_b1;                                // R20
      lower_sel = !match_b1 && match_b2;
      board_en  = upper_sel || lower_sel;
    end else if (cfg[CFG_SINGLE_ADDR]) begin
      board_en  = match_b1;                                // R06
    end else if (cfg[CFG_QUAD_ADDR]) begin
      board_en  = match_quad;                              // R07 R11 R12
    end else begin
      board_en  = 1'b0;
    end
  end

  // Lower lines carry upper digits when those are addressed
  assign next_low     = upper_sel ? stored_value[DATA_W-1:HALF_W]
                                  : stored_value[HALF_W-1:0];  // R20
  assign next_low_oe  = board_en;
  assign next_high_oe = board_en && !mux_mode;             // R03

  // ==========================================================
  // Pin registers, with the polarity strap applied
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bcd_low_o  <= '0;
      bcd_high_o <= '0;
      dp_code_o  <= '0;
      polarity_o <= 1'b0;
    end else begin
      bcd_low_o  <= next_low ^ {HALF_W{invert}};          // R01 R13 R14
      bcd_high_o <= stored_value[DATA_W-1:HALF_W] ^ {HALF_W{invert}};
      dp_code_o  <= stored_aux[AUX_DP_LSB +: DP_W] ^ {DP_W{invert}};
      polarity_o <= stored_aux[AUX_SIGN] ^ invert;
    end
  end

  // Overflow line only with the routing strap
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overflow_out_line_o    <= 1'b0;
      overflow_out_line_oe_o <= 1'b0;
    end else begin
      overflow_out_line_o    <= stored_aux[AUX_OVF];
      overflow_out_line_oe_o <= board_en &&
                                cfg[CFG_OVF_ROUTE];        // R04
    end
  end

  // Output enables: released whenever not addressed
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bcd_low_oe_o  <= 1'b0;
      bcd_high_oe_o <= 1'b0;
      dp_code_oe_o  <= 1'b0;
      polarity_oe_o <= 1'b0;
    end else begin
      bcd_low_oe_o  <= next_low_oe;                        // R02
      bcd_high_oe_o <= next_high_oe;
      dp_code_oe_o  <= board_en;
      polarity_oe_o <= board_en;
    end
  end

endmodule // bcd_parallel_output_port

// [sim/bcd_port_monitor.sv]
`timescale 1ns/100ps
// ==========================================================
// Port checker
module bcd_port_monitor
  import bcd_port_pkg::*;
#(
  parameter logic [15:0] MARKER_CYCLES = 16'h0008
) (
  input wire logic              mclk_i,
  input wire logic              rstn_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              hold_n_i,
  input wire logic              bcd_low_oe_o,
  input wire logic              bcd_high_oe_o,
  input wire logic [DP_W-1:0]   dp_code_o,
  input wire logic              dp_code_oe_o,
  input wire logic              polarity_oe_o,
  input wire logic              overflow_out_line_oe_o,
  input wire logic              data_ready_n_o
);
  logic [15:0] low_cnt;

  // Length of the current marker pulse
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i)
      low_cnt <= 16'h0000;
    else if (!data_ready_n_o)
      low_cnt <= low_cnt + 16'h0001;
    else
      low_cnt <= 16'h0000;
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_dp_range;
    dp_code_oe_o |-> (dp_code_o >= 3'h1 && dp_code_o <= 3'h6);
  endproperty
  a_dp_range: assert property (p_dp_range)
    else $error("point code out of range");
  property p_oe_tie;
    (dp_code_oe_o == polarity_oe_o) && (dp_code_oe_o == bcd_low_oe_o);
  endproperty
  a_oe_tie: assert property (p_oe_tie)
    else $error("drive enables disagree");
  property p_high_oe;
    bcd_high_oe_o |-> bcd_low_oe_o;
  endproperty
  a_high_oe: assert property (p_high_oe)
    else $error("upper group driven alone");
  property p_ovf_oe;
    overflow_out_line_oe_o |-> dp_code_oe_o;
  endproperty
  a_ovf_oe: assert property (p_ovf_oe)
    else $error("overflow driven while board off");
  property p_hold;
    $fell(data_ready_n_o) |-> $past(hold_n_i);
  endproperty
  a_hold: assert property (p_hold)
    else $error("update while held");
  property p_marker_min;
    $fell(data_ready_n_o) |-> (!data_ready_n_o) [*8];
  endproperty
  a_marker_min: assert property (p_marker_min)
    else $error("marker too short");
  property p_marker_len;
    $rose(data_ready_n_o) |-> low_cnt >= MARKER_CYCLES + 16'h0001;
  endproperty
  a_marker_len: assert property (p_marker_len)
    else $error("marker length wrong");
  property p_ready;
    psel_i && penable_i |-> pready_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("no ready in access");
  property p_err;
    psel_i && !penable_i && paddr_i > 8'h0C |=> pslverr_o;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not refused");

  c_mark: cover property ($fell(data_ready_n_o));
  c_ovf: cover property (overflow_out_line_oe_o);
  c_err: cover property (psel_i && penable_i && pslverr_o);
endmodule // bcd_port_monitor

bind bcd_parallel_output_port bcd_port_monitor #(
  .MARKER_CYCLES(MARKER_CYCLES)
) u_bcd_port_monitor (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .hold_n_i(hold_n_i),
  .bcd_low_oe_o(bcd_low_oe_o), .bcd_high_oe_o(bcd_high_oe_o),
  .dp_code_o(dp_code_o), .dp_code_oe_o(dp_code_oe_o),
  .polarity_oe_o(polarity_oe_o),
  .overflow_out_line_oe_o(overflow_out_line_oe_o),
  .data_ready_n_o(data_ready_n_o)
);

// [sim/bcd_reader_model.sv]
`timescale 1ns/100ps
// ==========================================================
// Printer side: drives address and hold, reads the lines
module bcd_reader_model (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic [3:0]  line_req_i,
  input  wire logic        hold_req_i,
  output logic             addr_b1_line_o,
  output logic             addr_b2_line_o,
  output logic             addr_b4_line_o,
  output logic             addr_b8_line_o,
  output logic             hold_n_o,
  input  wire logic [11:0] bcd_low_i,
  input  wire logic        bcd_low_oe_i,
  input  wire logic [11:0] bcd_high_i,
  input  wire logic        bcd_high_oe_i,
  input  wire logic [2:0]  dp_i,
  input  wire logic        dp_oe_i,
  input  wire logic        pol_i,
  input  wire logic        pol_oe_i,
  input  wire logic        ovf_i,
  input  wire logic        ovf_oe_i,
  output logic [28:0]      view_o
);
  // Lines held as levels, open means high
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {addr_b8_line_o, addr_b4_line_o} <= 2'h3;
      {addr_b2_line_o, addr_b1_line_o} <= 2'h3;
      hold_n_o <= 1'b1;
    end else begin
      addr_b8_line_o <= line_req_i[3];
      addr_b4_line_o <= line_req_i[2];
      addr_b2_line_o <= line_req_i[1];
      addr_b1_line_o <= line_req_i[0];
      hold_n_o <= !hold_req_i;
    end
  end

  // Undriven inputs float to the pulled-up level
  assign view_o = {bcd_high_oe_i ? bcd_high_i : 12'hFFF,
                   bcd_low_oe_i ? bcd_low_i : 12'hFFF,
                   dp_oe_i ? dp_i : 3'h7,
                   pol_oe_i ? pol_i : 1'b1,
                   ovf_oe_i ? ovf_i : 1'b1};
endmodule // bcd_reader_model

// [sim/tb_top.sv]
`timescale 1ns/100ps
// ==========================================================
// Testbench
module tb_top;
  import bcd_port_pkg::*;
  localparam logic [15:0] MK = 16'h0008;
  localparam logic [28:0] OFF = 29'h1FFFFFFF;
  localparam logic [28:0] ON = {24'h123456, 3'h6, 1'b1, 1'b1};
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready, pslverr, hold_n, b1, b2, b4, b8;
  logic [11:0] lo, hi;
  logic        lo_oe, hi_oe, dp_oe, pol, pol_oe, ovf, ovf_oe, rdy_n;
  logic [2:0]  dp;
  logic [3:0]  line_req = 4'hF;
  logic        hold_req = 1'b0;
  logic [28:0] view;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #2 mclk = ~mclk;

  bcd_parallel_output_port #(.MARKER_CYCLES(MK)) u_bcd_parallel_output_port (
    .mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .hold_n_i(hold_n), .addr_b1_line_i(b1),
    .addr_b2_line_i(b2), .addr_b4_line_i(b4), .addr_b8_line_i(b8),
    .bcd_low_o(lo), .bcd_low_oe_o(lo_oe), .bcd_high_o(hi),
    .bcd_high_oe_o(hi_oe), .dp_code_o(dp), .dp_code_oe_o(dp_oe),
    .polarity_o(pol), .polarity_oe_o(pol_oe),
    .overflow_out_line_o(ovf), .overflow_out_line_oe_o(ovf_oe),
    .data_ready_n_o(rdy_n));

  bcd_reader_model u_bcd_reader_model (
    .mclk_i(mclk), .rstn_i(rstn), .line_req_i(line_req),
    .hold_req_i(hold_req), .addr_b1_line_o(b1), .addr_b2_line_o(b2),
    .addr_b4_line_o(b4), .addr_b8_line_o(b8), .hold_n_o(hold_n),
    .bcd_low_i(lo), .bcd_low_oe_i(lo_oe), .bcd_high_i(hi),
    .bcd_high_oe_i(hi_oe), .dp_i(dp), .dp_oe_i(dp_oe), .pol_i(pol),
    .pol_oe_i(pol_oe), .ovf_i(ovf), .ovf_oe_i(ovf_oe), .view_o(view));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, x);
    cmp({31'h0, e}, {31'h0, xe});
  endtask

  task automatic pins(input logic [28:0] x);
    repeat (4) @(posedge mclk);
    cmp({3'h0, view}, {3'h0, x});
  endtask

  // Marker must fall and stay low for its full length
  task automatic mark();
    int n;
    n = 0;
    while (rdy_n !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (rdy_n === 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    cmp(32'(n), 32'(MK) + 32'h1);
  endtask

  task automatic t_reset();
    rd(CFG_OFFSET, 32'h00000828, 1'b0);
    rd(AUX_OFFSET, 32'h00000001, 1'b0);
    wr(AUX_OFFSET, 32'h00000017);
    rd(AUX_OFFSET, 32'h00000011, 1'b0);
    rd(VALUE_OFFSET, 32'h00000000, 1'b0);
    rd(8'h40, 32'h00000000, 1'b1);
    pins({24'h000000, 3'h1, 1'b0, 1'b1});
  endtask

  task automatic t_update();
    wr(CFG_OFFSET, 32'h00000829);
    wr(AUX_OFFSET, 32'h0000000E);
    wr(VALUE_OFFSET, 32'h00123456);
    mark();
    pins({24'h123456, 3'h6, 1'b1, 1'b0});
    wr(CFG_OFFSET, 32'h00000828);
    pins(ON);
  endtask

  task automatic t_polarity();
    wr(CFG_OFFSET, 32'h00000428);
    pins({24'hEDCBA9, 3'h1, 1'b0, 1'b1});
    wr(CFG_OFFSET, 32'h00000828);
    pins(ON);
  endtask

  // Each line off its level disables, all on it enables
  task automatic t_quad();
    for (int s = 0; s < 2; s++) begin
      wr(CFG_OFFSET, s ? 32'h00000BE8 : 32'h00000828);
      for (int i = 0; i < 4; i++) begin
        line_req <= s ? 4'(1 << i) : ~4'(1 << i);
        pins(OFF);
      end
      line_req <= s ? 4'h0 : 4'hF;
      pins(ON);
    end
  endtask

  task automatic t_single();
    wr(CFG_OFFSET, 32'h00000824);
    line_req <= 4'h1;
    pins(ON);
    line_req <= 4'hE;
    pins(OFF);
  endtask

  task automatic t_mux();
    wr(CFG_OFFSET, 32'h00000816);
    line_req <= 4'h1;
    pins({24'hFFF123, 3'h6, 1'b1, 1'b1});
    line_req <= 4'h2;
    pins({24'hFFF456, 3'h6, 1'b1, 1'b1});
    line_req <= 4'h0;
    pins(OFF);
    wr(CFG_OFFSET, 32'h00000828);
    line_req <= 4'hF;
    pins(ON);
  endtask

  task automatic t_hold();
    hold_req <= 1'b1;
    wr(VALUE_OFFSET, 32'h00654321);
    repeat (20) @(posedge mclk);
    cmp({31'h0, rdy_n}, 32'h1);
    pins(ON);
    rd(STATUS_OFFSET, 32'h0000010B, 1'b0);
    hold_req <= 1'b0;
    mark();
    pins({24'h654321, 3'h6, 1'b1, 1'b1});
  endtask

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_update();
    t_polarity();
    t_quad();
    t_single();
    t_mux();
    t_hold();
    wrap_up();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end
endmodule // tb_top
